// ===== verilog/csd_top.sv
// Purpose: four programmable chip selects with wait states, AXI4-Lite setup
// Assumes: external address and cycle strobes are synchronous to aclk
// Notes: selects and wait request appear one clock after the strobe rises
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
module csd_top
  import csd_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [CSD_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [CSD_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [CSD_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [CSD_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // external access side
  input wire logic [23:0] bus_addr,
  input wire logic mem_cycle,
  input wire logic io_cycle,
  input wire logic [3:0] native_mode,
  output logic [3:0] chip_sel_n,
  output logic wait_req
);

  // map a byte address onto a register slot, none when unmapped
  function automatic logic [3:0] csd_slot(input logic [CSD_AW-1:0] a);
    logic [9:0] idx;
    idx = a[CSD_AW-1:2];
    if (a[1:0] != 2'h0 || idx < CSD_IDX_SEL0_LOW || idx > CSD_IDX_STATUS)
      return CSD_SLOT_NONE;
    return 4'(idx - CSD_IDX_SEL0_LOW);
  endfunction : csd_slot

  csd_dec_if dec_if ();

  logic [3:0][7:0] low_r;
  logic [3:0][7:0] high_r;
  logic [3:0][7:0] ctl_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [CSD_DW-1:0] rdata_r;
  logic [CSD_AW-1:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic aw_held_r, w_held_r;
  csd_state_t state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic [3:0] sel_n_r;
  logic wait_r;
  logic [3:0] last_hit_r;

  // ========================================================================
  // write path decode
  wire aw_take = awvalid && awready_r;
  wire w_take = wvalid && wready_r;
  wire do_write = aw_held_r && w_held_r && !bvalid_r;
  wire [3:0] wr_slot = csd_slot(awaddr_r);
  wire wr_en = do_write && wlane_r && (wr_slot != CSD_SLOT_NONE) && (wr_slot != CSD_SLOT_STATUS);
  wire wr_bad = (wr_slot == CSD_SLOT_NONE);
  wire b_done = bvalid_r && bready;

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awaddr_r <= '0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= awaddr;
      end else if (b_done) begin
        aw_held_r <= 1'b0;
        awready_r <= 1'b1;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
        wbyte_r <= wdata[7:0];
        wlane_r <= wstrb[0]; // only the low lane carries data
      end else if (b_done) begin
        w_held_r <= 1'b0;
        wready_r <= 1'b1;
      end
    end
  end

  // response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= CSD_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_bad ? CSD_RESP_SLVERR : CSD_RESP_OKAY;
    end else if (b_done) begin
      bvalid_r <= 1'b0;
    end
  end

  // ========================================================================
  // setup registers, one set per channel
  genvar i;
  generate
    for (i = 0; i < CSD_NCH; i++) begin : g_reg
      localparam logic [3:0] SLOT_LOW = 4'(3 * i);
      localparam logic [3:0] SLOT_HIGH = 4'(3 * i + 1);
      localparam logic [3:0] SLOT_CTL = 4'(3 * i + 2);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          low_r[i] <= CSD_LOW_RST[8*i+:8]; // RULE_12
          high_r[i] <= CSD_HIGH_RST[8*i+:8]; // RULE_05
          ctl_r[i] <= CSD_CTL_RST[8*i+:8]; // RULE_06
        end else if (wr_en) begin
          if (wr_slot == SLOT_LOW)
            low_r[i] <= wbyte_r;
          if (wr_slot == SLOT_HIGH)
            high_r[i] <= wbyte_r;
          if (wr_slot == SLOT_CTL)
            ctl_r[i] <= wbyte_r & CSD_CTL_WMASK; // RULE_10
        end
      end
    end
  endgenerate

  // ========================================================================
  // read path: flat view of all slots
  logic [15:0][7:0] view;
  generate
    for (i = 0; i < CSD_NCH; i++) begin : g_view
      assign view[3*i] = low_r[i];
      assign view[3*i+1] = high_r[i];
      assign view[3*i+2] = ctl_r[i];
    end
  endgenerate
  // status: last winning channel, wait busy, three zero bits
  assign view[12] = {last_hit_r, wait_r, 3'h0};
  assign view[13] = 8'h00;
  assign view[14] = 8'h00;
  assign view[15] = 8'h00;

  wire ar_take = arvalid && arready_r;
  wire [3:0] rd_slot = csd_slot(araddr);
  wire r_done = rvalid_r && rready;

  // one read at a time, answered the cycle after it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= CSD_RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, view[rd_slot]};
      rresp_r <= (rd_slot == CSD_SLOT_NONE) ? CSD_RESP_SLVERR : CSD_RESP_OKAY;
    end else if (r_done) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // ========================================================================
  // decoder hookup
  assign dec_if.low_bound = low_r;
  assign dec_if.high_bound = high_r;
  assign dec_if.ctl = ctl_r;
  assign dec_if.native_mode = native_mode;
  assign dec_if.addr = bus_addr;
  assign dec_if.mem_cycle = mem_cycle;
  assign dec_if.io_cycle = io_cycle;

  csd_decode u_decode (
    .dec (dec_if.decoder)
  );

  // ========================================================================
  // access sequencer: select is latched at the start so a bound write
  // during a long access cannot drop the select halfway
  wire cyc = mem_cycle || io_cycle;
  wire go = cyc && (dec_if.hit != 4'h0);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sel_nxt = sel_r;
    unique case (state_r)
      CSD_IDLE: begin
        if (go) begin
          sel_nxt = dec_if.hit;
          cnt_nxt = dec_if.wait_cnt; // RULE_07 RULE_11
          state_nxt = (dec_if.wait_cnt != 3'h0) ? CSD_WAIT : CSD_HOLD;
        end
      end
      CSD_WAIT: begin
        cnt_nxt = cnt_r - 3'h1; // RULE_07
        if (!cyc) begin
          state_nxt = CSD_IDLE;
          cnt_nxt = 3'h0;
          sel_nxt = 4'h0;
        end else if (cnt_r == 3'h1) begin
          state_nxt = CSD_HOLD;
        end
      end
      CSD_HOLD: begin
        if (!cyc) begin
          state_nxt = CSD_IDLE;
          sel_nxt = 4'h0;
        end
      end
      default: begin
        state_nxt = CSD_IDLE;
        cnt_nxt = 3'h0;
        sel_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= CSD_IDLE;
      cnt_r <= 3'h0;
      sel_r <= 4'h0;
      sel_n_r <= 4'hf;
      wait_r <= 1'b0;
      last_hit_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sel_r <= sel_nxt;
      sel_n_r <= ~sel_nxt; // active-low copy so the pin comes straight from a flop
      wait_r <= (state_nxt == CSD_WAIT);
      if (state_r == CSD_IDLE && go)
        last_hit_r <= dec_if.hit;
    end
  end

  // ========================================================================
  // outputs straight from flops
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign chip_sel_n = sel_n_r;
  assign wait_req = wait_r;

  // ========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  generate
    for (i = 0; i < CSD_NCH; i++) begin : g_chk
      chk_reset_values: assert property ($past(!aresetn) |-> low_r[i] == 8'h00 && high_r[i] == CSD_HIGH_RST[8*i+:8]
          && ctl_r[i] == CSD_CTL_RST[8*i+:8]) // RULE_05
        else $error("setup byte reset value wrong");
      chk_reserved_zero: assert property (ctl_r[i][2:0] == 3'h0) // RULE_10
        else $error("reserved control bits not zero");
      chk_enable_gate: assert property (dec_if.hit[i] |-> ctl_r[i][CSD_CTL_EN_BIT]) // RULE_09
        else $error("disabled channel selected");
      chk_mem_range: assert property (dec_if.hit[i] && !ctl_r[i][CSD_CTL_TYPE_BIT] |-> mem_cycle
          && bus_addr[23:16] >= low_r[i] && bus_addr[23:16] <= high_r[i]) // RULE_02
        else $error("memory select outside bounds");
      chk_io_match: assert property (dec_if.hit[i] && ctl_r[i][CSD_CTL_TYPE_BIT] |-> io_cycle
          && bus_addr[15:8] == low_r[i]) // RULE_03
        else $error("io select without match");
    end
  endgenerate

  chk_ctl0_reset: assert property ($past(!aresetn) |-> ctl_r[0] == 8'he8 && high_r[0] == 8'hff) // RULE_06
    else $error("channel 0 reset setup wrong");
  // winner is one raw match, and no lower channel matched as well
  chk_lowest_wins: assert property ($onehot0(dec_if.hit) && (dec_if.hit & ~u_decode.raw_hit) == 4'h0
      && (u_decode.raw_hit & (dec_if.hit - 4'h1)) == 4'h0) // RULE_13
    else $error("priority between channels broken");
  chk_wait_length: assert property (state_r == CSD_IDLE && go && dec_if.wait_cnt == 3'h3 |=>
      (wait_req && cyc)[*2] ##1 wait_req ##1 !wait_req) // RULE_07
    else $error("wait length differs from count");
  chk_no_wait_nonnative: assert property (state_r == CSD_IDLE && go && (dec_if.hit & native_mode) == 4'h0
      |=> !wait_req) // RULE_11
    else $error("wait inserted outside native mode");
  chk_select_follows: assert property (state_r == CSD_IDLE && go |=> chip_sel_n == ~$past(dec_if.hit)) // RULE_01
    else $error("select output does not follow decode");
  chk_write_resp: assert property (do_write |=> bvalid && bresp == ($past(wr_bad) ? CSD_RESP_SLVERR : CSD_RESP_OKAY))
    else $error("write response missing");

  cov_io_select: cover property (state_r == CSD_IDLE && go && io_cycle);
  cov_mem_wait: cover property (state_r == CSD_IDLE && go && mem_cycle && dec_if.wait_cnt == 3'h7);
  cov_overlap: cover property (state_r == CSD_IDLE && go && !$onehot0(u_decode.raw_hit));
  cov_bad_read: cover property (rvalid && rresp == CSD_RESP_SLVERR);

endmodule : csd_top

// ===== verilog/csd_pkg.sv
// Purpose: constants and types shared by the chip-select decoder files
// Assumes: 40 MHz aclk, synchronous active-low reset, AXI4-Lite register access
// Notes: register offsets are word indices; the byte address is four times the index
// ==========================================================================
// How it works
// RULE_01: memory channel compares address high byte with low bound
// RULE_02: memory select only inside bounds and when enabled
// RULE_03: I/O channel matches address middle byte to low bound
// RULE_04: I/O channel ignores its high bound
// RULE_05: reset high bounds: channel 0 ff, others 00
// RULE_06: reset control: channel 0 e8, others 00
// RULE_07: control bits 7:5 give zero to seven waits
// RULE_08: control bit 4 picks memory or I/O type
// RULE_09: control bit 3 enables the channel select
// RULE_10: control bits 2:0 read zero, not writable
// RULE_11: wait count applies only in native bus mode
// RULE_12: low bounds of all channels reset to zero
// RULE_13: inclusive range; lowest matching channel wins
package csd_pkg;

  // ========================================================================
  // sizes
  localparam int CSD_NCH = 4;
  localparam int CSD_AW = 12;
  localparam int CSD_DW = 32;

  // ========================================================================
  // register indices (byte address = index * 4)
  localparam logic [9:0] CSD_IDX_SEL0_LOW = 10'h0a8;
  localparam logic [9:0] CSD_IDX_SEL0_HIGH = 10'h0a9;
  localparam logic [9:0] CSD_IDX_SEL0_CTL = 10'h0aa;
  localparam logic [9:0] CSD_IDX_SEL1_LOW = 10'h0ab;
  localparam logic [9:0] CSD_IDX_SEL1_HIGH = 10'h0ac;
  localparam logic [9:0] CSD_IDX_SEL1_CTL = 10'h0ad;
  localparam logic [9:0] CSD_IDX_SEL2_LOW = 10'h0ae;
  localparam logic [9:0] CSD_IDX_SEL2_HIGH = 10'h0af;
  localparam logic [9:0] CSD_IDX_SEL2_CTL = 10'h0b0;
  localparam logic [9:0] CSD_IDX_SEL3_LOW = 10'h0b1;
  localparam logic [9:0] CSD_IDX_SEL3_HIGH = 10'h0b2;
  localparam logic [9:0] CSD_IDX_SEL3_CTL = 10'h0b3;
  localparam logic [9:0] CSD_IDX_STATUS = 10'h0b4;
  localparam logic [3:0] CSD_SLOT_STATUS = 4'hc;
  localparam logic [3:0] CSD_SLOT_NONE = 4'hf;

  // ========================================================================
  // control byte fields
  localparam int CSD_CTL_WAIT_LSB = 5;
  localparam int CSD_CTL_TYPE_BIT = 4;
  localparam int CSD_CTL_EN_BIT = 3;
  localparam logic [7:0] CSD_CTL_WMASK = 8'hf8;

  // ========================================================================
  // reset values, channel i in bits [8i+7:8i]
  localparam logic [31:0] CSD_LOW_RST = 32'h0000_0000;
  localparam logic [31:0] CSD_HIGH_RST = 32'h0000_00ff;
  localparam logic [31:0] CSD_CTL_RST = 32'h0000_00e8;

  // ========================================================================
  // bus answers
  localparam logic [1:0] CSD_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSD_RESP_SLVERR = 2'h2;

  // access sequencer states
  typedef enum logic [2:0] {
    CSD_IDLE = 3'b001,
    CSD_WAIT = 3'b010,
    CSD_HOLD = 3'b100
  } csd_state_t;

endpackage : csd_pkg

// ===== verilog/csd_dec_if.sv
// Purpose: carries channel setup and the decode answer between top and decoder
// Assumes: purely combinational decode on the far side
// Notes: packed arrays, channel i in element i
`timescale 1ns/100ps
interface csd_dec_if;
  logic [3:0][7:0] low_bound;
  logic [3:0][7:0] high_bound;
  logic [3:0][7:0] ctl;
  logic [3:0] native_mode;
  logic [23:0] addr;
  logic mem_cycle;
  logic io_cycle;
  logic [3:0] hit;
  logic [2:0] wait_cnt;

  modport owner (output low_bound, high_bound, ctl, native_mode, addr, mem_cycle, io_cycle,
                 input hit, wait_cnt);
  modport decoder (input low_bound, high_bound, ctl, native_mode, addr, mem_cycle, io_cycle,
                   output hit, wait_cnt);
endinterface : csd_dec_if

// ===== verilog/csd_decode.sv
// Purpose: address compare for four chip-select channels with priority
// Assumes: setup bytes are stable while an access is decoded
// Notes: combinational; the top registers the result
`timescale 1ns/100ps
module csd_decode
  import csd_pkg::*;
(
  // decode link
  csd_dec_if.decoder dec
);

  logic [3:0] raw_hit;
  logic [3:0] chan_wait_or [0:4];

  // ========================================================================
  // per-channel compare
  genvar i;
  generate
    for (i = 0; i < CSD_NCH; i++) begin : g_ch
      wire en = dec.ctl[i][CSD_CTL_EN_BIT]; // RULE_09
      wire is_io = dec.ctl[i][CSD_CTL_TYPE_BIT]; // RULE_08
      // inclusive compare on the high address byte
      wire in_range = (dec.addr[23:16] >= dec.low_bound[i]) && (dec.addr[23:16] <= dec.high_bound[i]); // RULE_01 RULE_02 RULE_13
      // io match never looks at the high bound
      wire io_match = (dec.addr[15:8] == dec.low_bound[i]); // RULE_03 RULE_04
      assign raw_hit[i] = en && (is_io ? (dec.io_cycle && io_match) : (dec.mem_cycle && in_range));
    end
  endgenerate

  // lowest set bit only
  assign dec.hit = raw_hit & (~raw_hit + 4'h1); // RULE_13

  // ========================================================================
  // wait count of the winner, zero outside native mode
  assign chan_wait_or[0] = 4'h0;
  generate
    for (i = 0; i < CSD_NCH; i++) begin : g_wait
      wire [2:0] cnt = dec.ctl[i][7:CSD_CTL_WAIT_LSB]; // RULE_07
      assign chan_wait_or[i + 1] = chan_wait_or[i] | ((dec.hit[i] && dec.native_mode[i]) ? {1'b0, cnt} : 4'h0); // RULE_11
    end
  endgenerate
  assign dec.wait_cnt = chan_wait_or[4][2:0];

endmodule : csd_decode

// ===== verif/csd_ext_model.sv
// Purpose: far-side memory/peripheral model that records what each access saw
// Assumes: one access at a time, strobes low between accesses
// Notes: results hold after the strobes drop so the bench can read them late
`timescale 1ns/100ps
module csd_ext_model (
  // clock
  input wire logic aclk,
  // access strobes and select side
  input wire logic mem_cycle,
  input wire logic io_cycle,
  input wire logic [3:0] chip_sel_n,
  input wire logic wait_req,
  // what the last access saw
  output logic [3:0] sel_seen,
  output logic [3:0] waits_seen
);
  // ========================================================================
  // capture
  logic act_r = 1'b0;

  // fresh record on strobe rise; select and waits gathered until the next rise
  always_ff @(posedge aclk) begin
    act_r <= mem_cycle | io_cycle;
    if ((mem_cycle | io_cycle) && !act_r) begin
      sel_seen <= 4'hf;
      waits_seen <= 4'h0;
    end else begin
      sel_seen <= sel_seen & chip_sel_n; // any low bit ever seen stays low
      if (wait_req) begin
        waits_seen <= waits_seen + 4'h1;
      end
    end
  end
endmodule : csd_ext_model

// ===== verif/test_chip_select_decoder.sv
// Purpose: self-checking bench for the chip-select decoder top
// Assumes: AXI4-Lite master driven on rising edges, one access at a time
// Notes: register byte address is four times the register index
`timescale 1ns/100ps
module test_chip_select_decoder;
  import csd_pkg::*;
  // ========================================================================
  // signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, wait_req;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] bus_addr = 24'h0;
  logic mem_cycle = 1'b0, io_cycle = 1'b0;
  logic [3:0] native_mode = 4'hf;
  logic [3:0] chip_sel_n, sel_seen, waits_seen;
  int errors = 0;
  int tests_run = 0;

  always #12.5 aclk = ~aclk;

  csd_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .bus_addr(bus_addr), .mem_cycle(mem_cycle), .io_cycle(io_cycle), .native_mode(native_mode),
    .chip_sel_n(chip_sel_n), .wait_req(wait_req));

  csd_ext_model ext (.aclk(aclk), .mem_cycle(mem_cycle), .io_cycle(io_cycle), .chip_sel_n(chip_sel_n),
    .wait_req(wait_req), .sel_seen(sel_seen), .waits_seen(waits_seen));

  // ========================================================================
  // shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [11:0] ra(input int ch, input int k);
    return 12'((int'(CSD_IDX_SEL0_LOW) + 3 * ch + k) * 4);
  endfunction : ra

  // address and data offered together; bready and rready stay high between transfers
  task axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask : axi_write

  task axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : axi_read

  task wr(input int ch, input int k, input logic [7:0] v);
    logic [1:0] r;
    axi_write(ra(ch, k), {24'h0, v}, r);
    check(r, CSD_RESP_OKAY);
  endtask : wr

  task rd(input int ch, input int k, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(ra(ch, k), d, r);
    check(d, {24'h0, e});
    check(r, CSD_RESP_OKAY);
  endtask : rd

  // strobe held long enough for seven waits, then released and judged
  task access(input logic [23:0] a, input logic m, input logic io, input logic [3:0] es, input logic [3:0] ew);
    bus_addr <= a;
    mem_cycle <= m;
    io_cycle <= io;
    repeat (12) @(posedge aclk);
    mem_cycle <= 1'b0;
    io_cycle <= 1'b0;
    repeat (3) @(posedge aclk);
    check(sel_seen, es);
    check(waits_seen, ew);
    check(chip_sel_n, 4'hf);
  endtask : access

  // ========================================================================
  // scenarios
  task t_reset_values;
    for (int c = 0; c < 4; c++) begin
      rd(c, 0, 8'h00);
      rd(c, 1, c == 0 ? 8'hff : 8'h00);
      rd(c, 2, c == 0 ? 8'he8 : 8'h00);
    end
  endtask : t_reset_values

  task t_reg_access;
    logic [31:0] d;
    logic [1:0] r;
    wr(1, 2, 8'hff);
    rd(1, 2, 8'hf8);
    wr(1, 0, 8'ha5);
    rd(1, 0, 8'ha5);
    wr(1, 1, 8'h5a);
    rd(1, 1, 8'h5a);
    wr(1, 2, 8'h00);
    axi_read(12'h000, d, r);
    check(r, CSD_RESP_SLVERR);
    check(d, 32'h0);
    axi_write(12'h000, 32'hff, r);
    check(r, CSD_RESP_SLVERR);
  endtask : t_reg_access

  task t_default_select;
    access(24'h123456, 1'b1, 1'b0, 4'he, 4'h7);
    native_mode <= 4'he;
    access(24'h123456, 1'b1, 1'b0, 4'he, 4'h0);
    native_mode <= 4'hf;
  endtask : t_default_select

  task t_wait_counts;
    for (int n = 0; n < 8; n++) begin
      wr(0, 2, {3'(n), 5'b01000});
      access(24'hff0000, 1'b1, 1'b0, 4'he, 4'(n));
    end
  endtask : t_wait_counts

  task t_mem_range;
    wr(0, 2, 8'h00);
    wr(1, 0, 8'h20);
    wr(1, 1, 8'h30);
    wr(1, 2, 8'h08);
    access(24'h1fffff, 1'b1, 1'b0, 4'hf, 4'h0);
    access(24'h200000, 1'b1, 1'b0, 4'hd, 4'h0);
    access(24'h30ffff, 1'b1, 1'b0, 4'hd, 4'h0);
    access(24'h310000, 1'b1, 1'b0, 4'hf, 4'h0);
    wr(1, 2, 8'h00);
    access(24'h250000, 1'b1, 1'b0, 4'hf, 4'h0);
  endtask : t_mem_range

  task t_io_select;
    wr(2, 0, 8'h55);
    wr(2, 2, 8'h38);
    access(24'hab55cd, 1'b0, 1'b1, 4'hb, 4'h1);
    access(24'hab56cd, 1'b0, 1'b1, 4'hf, 4'h0);
    access(24'h555500, 1'b1, 1'b0, 4'hf, 4'h0);
    wr(2, 1, 8'hff);
    access(24'h0055ff, 1'b0, 1'b1, 4'hb, 4'h1);
  endtask : t_io_select

  task t_priority;
    wr(1, 2, 8'h08);
    wr(3, 0, 8'h20);
    wr(3, 1, 8'h30);
    wr(3, 2, 8'h48);
    access(24'h250000, 1'b1, 1'b0, 4'hd, 4'h0);
    wr(1, 2, 8'h00);
    access(24'h250000, 1'b1, 1'b0, 4'h7, 4'h2);
    // status is read only: a write is answered but changes nothing
    wr(4, 0, 8'hff);
    rd(4, 0, 8'h80);
  endtask : t_priority

  // ========================================================================
  // verdict and run control
  task give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // hang guard well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_reg_access();
    t_default_select();
    t_wait_counts();
    t_mem_range();
    t_io_select();
    t_priority();
    give_verdict();
  end
endmodule : test_chip_select_decoder
